// ---- shared/rsp_consts.vh ----
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// System clock rate and reduced-interface reference rate, in MHz.
`define RSP_SYS_MHZ 250
`define RSP_REF_MHZ 50
// Crystal rate in MHz, kept for reference only; the clock-mode divider uses the system and reference rates instead.
`define RSP_XTAL_MHZ 25
// System clocks per reference clock period.
`define RSP_REF_DIV (`RSP_SYS_MHZ / `RSP_REF_MHZ)
// Divider count at which the reference output rises and falls.
`define RSP_REF_HIGH 3'h0
`define RSP_REF_LOW 3'h2
// Divider count at which the internal timing beat is taken.
`define RSP_BEAT_CNT 3'h3

// Reference cycles each dibit is held at 10Mbps.
`define RSP_SLOW_HOLD 10
// Dibits per byte and FIFO depth in words.
`define RSP_DIBITS_PER_BYTE 4
`define RSP_FIFO_DEPTH 16

// Register offsets.
`define RSP_REG_CTRL 8'h57
`define RSP_REG_STAT 8'h58

// Control register fields and reset value.
`define RSP_CTRL_P3_SLOW 0
`define RSP_CTRL_P4_SLOW 1
`define RSP_CTRL_P4_CLK_OFF 3
`define RSP_CTRL_RESET 8'h00

// Status register fields; overflow bits are sticky, cleared by writing one.
`define RSP_STAT_P3_RMII 0
`define RSP_STAT_P4_RMII 1
`define RSP_STAT_CLK_NORMAL 2
`define RSP_STAT_P3_OVF 4
`define RSP_STAT_P4_OVF 5

`endif

// ---- verilog/rsp_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module rsp_sync #(
    parameter WIDTH = 1
) (
    // Clock.
    input wire clk_sys,
    // Asynchronous inputs and their synchronised copies.
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // Two stages with no reset, so straps are valid by the end of reset.
    always @(posedge clk_sys) begin
        meta_reg <= async_in;
        sync_reg <= meta_reg;
    end

    assign sync_out = sync_reg;

endmodule // rsp_sync

`default_nettype wire

// ---- verilog/rsp_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module rsp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Filling side.
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Draining side.
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    // Honest full and empty flags drive the handshakes.
    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage write.
    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth and the count tracks occupancy.
    always @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // rsp_fifo

`default_nettype wire

// ---- verilog/rsp_port.v ----
// Contract
// - Both ports carry traffic at 10Mbps and at 100Mbps.
// - Internal clocking: drive 50MHz reference out of each receive-clock pin.
// - External clocking: the 50MHz reference enters only the port 4 input.
// - Separate two-bit transmit and receive paths, one dibit per reference cycle.
// - Port 4 strap low at reset selects reduced mode for port 4.
// - Port 3 strap low at reset selects reduced mode for port 3.
// - MAC-facing: drive clock, valid and receive dibit; take enable and dibit.
// - PHY-facing: same pins, partner valid and dibit enter on transmit inputs.
// - MAC or PHY facing role needs no strap or register; wiring decides.
// - Clock-source strap low: port 4 accepts an external 50MHz reference.
// - Normal mode: all timing comes from the port 4 reference input.
// - Clock-source strap high: crystal mode, 50MHz out on each receive-clock pin.
// - Control bit 3 of register 87 stops the port 4 reference output.
`timescale 1ns/1ps
`default_nettype none
`include "rsp_consts.vh"

module rsp_port #(
    parameter FIFO_DEPTH = `RSP_FIFO_DEPTH,
    parameter FIFO_AW = 4,
    parameter SLOW_HOLD = `RSP_SLOW_HOLD
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst,
    // Strap pins, sampled as reset is released.
    input wire port3_iface_strap,
    input wire port4_iface_strap,
    input wire clock_source_strap,
    // Link pins, index 0 is port 3 and index 1 is port 4.
    input wire [1:0] ref_clock_in,
    output wire [1:0] ref_clock_out,
    input wire [1:0] tx_enable_in,
    input wire [3:0] tx_dibit_in,
    output wire [1:0] rx_valid_carrier_out,
    output wire [3:0] rx_dibit_out,
    // Switch side, frames received from the link, byte wide per port.
    output wire [15:0] sw_tx_data,
    output wire [1:0] sw_tx_first,
    output wire [1:0] sw_tx_valid,
    input wire [1:0] sw_tx_ready,
    // Switch side, frames to send on the link, byte wide per port.
    input wire [15:0] sw_rx_data,
    input wire [1:0] sw_rx_valid,
    output wire [1:0] sw_rx_ready,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata
);

    localparam integer REF_LAST = `RSP_REF_DIV - 1;
    localparam integer SLOW_LAST = SLOW_HOLD - 1;
    localparam integer DIBIT_LAST = `RSP_DIBITS_PER_BYTE - 1;

    // Synchronised copies of every pin input.
    wire [10:0] pins_s;
    wire port3_strap_s;
    wire port4_strap_s;
    wire clk_src_s;
    wire [1:0] ref_in_s;
    wire [1:0] txen_s;
    wire [3:0] txd_s;

    // Captured strap state and control.
    reg strap_done_reg;
    reg [1:0] rmii_reg;
    reg clk_normal_reg;
    reg [7:0] ctrl_reg;
    reg [1:0] ovf_reg;
    wire [1:0] ovf_set;
    reg [7:0] rdata_reg;

    // Reference timing.
    reg [2:0] div_cnt_reg;
    reg div_clk_reg;
    reg ref4_d_reg;
    wire ref4_rise;
    wire ref_tick;
    reg [1:0] ref_out_reg;

    rsp_sync #(
        .WIDTH(11)
    ) u_sync (
        .clk_sys(clk_sys),
        .async_in({clock_source_strap, port4_iface_strap, port3_iface_strap,
            ref_clock_in, tx_enable_in, tx_dibit_in}),
        .sync_out(pins_s)
    );

    // Split the synchronised bundle back into named signals.
    assign txd_s = pins_s[3:0];
    assign txen_s = pins_s[5:4];
    assign ref_in_s = pins_s[7:6];
    assign port3_strap_s = pins_s[8];
    assign port4_strap_s = pins_s[9];
    assign clk_src_s = pins_s[10];

    // Straps are caught once, on the first edge after reset is released.
    always @(posedge clk_sys) begin
        if (rst) begin
            strap_done_reg <= 1'b0;
            rmii_reg <= 2'h0;
            clk_normal_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            rmii_reg[0] <= ~port3_strap_s;
            rmii_reg[1] <= ~port4_strap_s;
            clk_normal_reg <= ~clk_src_s;
        end
    end

    // Divider that stands in for the crystal-derived 50MHz reference.
    always @(posedge clk_sys) begin
        if (rst) begin
            div_cnt_reg <= 3'h0;
            div_clk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= (div_cnt_reg == REF_LAST[2:0]) ? 3'h0 : div_cnt_reg + 1'b1;
            if (div_cnt_reg == `RSP_REF_HIGH) begin
                div_clk_reg <= 1'b1;
            end else if (div_cnt_reg == `RSP_REF_LOW) begin
                div_clk_reg <= 1'b0;
            end
        end
    end

    // Edge finder on the synchronised port 4 reference input.
    always @(posedge clk_sys) begin
        if (rst) begin
            ref4_d_reg <= ref_in_s[1]; // No false edge right after reset.
        end else begin
            ref4_d_reg <= ref_in_s[1];
        end
    end

    assign ref4_rise = ref_in_s[1] & ~ref4_d_reg;

    // One beat per reference period, from the port 4 input in normal mode.
    assign ref_tick = clk_normal_reg ? ref4_rise :
        (div_cnt_reg == `RSP_BEAT_CNT);

    // Reference outputs; port 3 repeats the port 4 input in normal mode, and its own input is never used.
    always @(posedge clk_sys) begin
        if (rst) begin
            ref_out_reg <= 2'h0;
        end else if (clk_normal_reg) begin
            ref_out_reg[0] <= rmii_reg[0] & ref_in_s[1];
            ref_out_reg[1] <= 1'b0;
        end else begin
            ref_out_reg[0] <= rmii_reg[0] & div_clk_reg;
            ref_out_reg[1] <= rmii_reg[1] & div_clk_reg &
                ~ctrl_reg[`RSP_CTRL_P4_CLK_OFF];
        end
    end

    assign ref_clock_out = ref_out_reg;

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            reg [3:0] slow_cnt_reg;
            wire slow;
            wire beat;
            reg [5:0] tx_acc_reg;
            reg [1:0] tx_cnt_reg;
            reg tx_first_reg;
            wire tx_push;
            wire tx_ready;
            wire [8:0] fifo_out;
            reg [5:0] rx_sh_reg;
            reg [1:0] rx_left_reg;
            reg rx_dv_reg;
            reg [1:0] rx_dib_reg;
            wire rx_take;

            assign slow = ctrl_reg[p];

            // Slow rate holds each dibit for a fixed count of beats.
            always @(posedge clk_sys) begin
                if (rst) begin
                    slow_cnt_reg <= 4'h0;
                end else if (ref_tick) begin
                    slow_cnt_reg <= (!slow || slow_cnt_reg == SLOW_LAST[3:0]) ? 4'h0 :
                        slow_cnt_reg + 1'b1;
                end
            end

            // A beat moves one dibit each way; one per period at 100Mbps.
            assign beat = ref_tick & rmii_reg[p] &
                (slow_cnt_reg == 4'h0);

            // Inbound path: the enable input frames the data on either role.
            always @(posedge clk_sys) begin
                if (rst) begin
                    tx_acc_reg <= 6'h0;
                    tx_cnt_reg <= 2'h0;
                    tx_first_reg <= 1'b1;
                end else if (beat) begin
                    if (txen_s[p]) begin
                        tx_acc_reg <= {txd_s[2*p+1:2*p], tx_acc_reg[5:2]};
                        tx_cnt_reg <= tx_cnt_reg + 1'b1;
                        if (tx_cnt_reg == DIBIT_LAST[1:0]) begin
                            tx_first_reg <= 1'b0;
                        end
                    end else begin
                        tx_cnt_reg <= 2'h0;
                        tx_first_reg <= 1'b1;
                    end
                end
            end

            // Four dibits, first in the low bits, make one byte.
            assign tx_push = beat & txen_s[p] & (tx_cnt_reg == DIBIT_LAST[1:0]);
            assign ovf_set[p] = tx_push & ~tx_ready;

            rsp_fifo #(
                .WIDTH(9),
                .DEPTH(FIFO_DEPTH),
                .AW(FIFO_AW)
            ) u_fifo (
                .clk_sys(clk_sys),
                .rst(rst),
                .in_valid(tx_push),
                .in_ready(tx_ready),
                .in_data({tx_first_reg, txd_s[2*p+1:2*p], tx_acc_reg}),
                .out_valid(sw_tx_valid[p]),
                .out_ready(sw_tx_ready[p]),
                .out_data(fifo_out)
            );

            assign sw_tx_data[8*p+7:8*p] = fifo_out[7:0];
            assign sw_tx_first[p] = fifo_out[8];

            // A new byte is taken only on a beat that finds the shifter empty or the output idle.
            assign rx_take = beat & ~(rx_dv_reg & (rx_left_reg != 2'h0));
            assign sw_rx_ready[p] = rx_take;

            // Outbound path: valid and dibit leave on their own pins.
            always @(posedge clk_sys) begin
                if (rst) begin
                    rx_sh_reg <= 6'h0;
                    rx_left_reg <= 2'h0;
                    rx_dv_reg <= 1'b0;
                    rx_dib_reg <= 2'h0;
                end else if (!rmii_reg[p]) begin
                    rx_dv_reg <= 1'b0;
                    rx_dib_reg <= 2'h0;
                end else if (beat) begin
                    if (rx_dv_reg && rx_left_reg != 2'h0) begin
                        rx_dib_reg <= rx_sh_reg[1:0];
                        rx_sh_reg <= {2'h0, rx_sh_reg[5:2]};
                        rx_left_reg <= rx_left_reg - 1'b1;
                    end else if (sw_rx_valid[p]) begin
                        rx_dv_reg <= 1'b1;
                        rx_dib_reg <= sw_rx_data[8*p+1:8*p];
                        rx_sh_reg <= sw_rx_data[8*p+7:8*p+2];
                        rx_left_reg <= DIBIT_LAST[1:0];
                    end else begin
                        rx_dv_reg <= 1'b0;
                        rx_dib_reg <= 2'h0;
                    end
                end
            end

            assign rx_valid_carrier_out[p] = rx_dv_reg;
            assign rx_dibit_out[2*p+1:2*p] = rx_dib_reg;
        end
    endgenerate

    // Control register; the role on the link is never configured here.
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= `RSP_CTRL_RESET;
        end else if (reg_wr && reg_addr == `RSP_REG_CTRL) begin
            ctrl_reg <= reg_wdata;
        end
    end

    // Sticky overflow flags; a new overflow wins over a clear.
    always @(posedge clk_sys) begin
        if (rst) begin
            ovf_reg <= 2'h0;
        end else if (reg_wr && reg_addr == `RSP_REG_STAT) begin
            ovf_reg <= (ovf_reg & ~{reg_wdata[`RSP_STAT_P4_OVF],
                reg_wdata[`RSP_STAT_P3_OVF]}) | ovf_set;
        end else begin
            ovf_reg <= ovf_reg | ovf_set;
        end
    end

    // Read data stand in the cycle after the read strobe; unmapped reads zero.
    always @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RSP_REG_CTRL: begin
                    rdata_reg <= ctrl_reg;
                end
                `RSP_REG_STAT: begin
                    rdata_reg <= {2'h0, ovf_reg, 1'b0, clk_normal_reg, rmii_reg};
                end
                default: begin
                    rdata_reg <= 8'h00;
                end
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule // rsp_port

`default_nettype wire

// ---- test/rsp_port_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rsp_consts.vh"
module rsp_port_monitor (
    // Clock, reset and straps.
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic port3_iface_strap,
    input wire logic port4_iface_strap,
    input wire logic clock_source_strap,
    // Link outputs.
    input wire logic [1:0] ref_clock_out,
    input wire logic [1:0] rx_valid_carrier_out,
    input wire logic [3:0] rx_dibit_out,
    // Switch side.
    input wire logic [15:0] sw_rx_data,
    input wire logic [1:0] sw_rx_valid,
    input wire logic [1:0] sw_rx_ready,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    logic off_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Follows the port 4 reference-off bit as software writes it.
    always @(posedge clk_sys) begin
        if (rst)
            off_reg <= 1'b0;
        else if (reg_wr && reg_addr == `RSP_REG_CTRL)
            off_reg <= reg_wdata[`RSP_CTRL_P4_CLK_OFF];
    end
    property p_ref_shape;
        clock_source_strap && $rose(ref_clock_out[0]) |=>
            ref_clock_out[0] ##1 !ref_clock_out[0] [*3] ##1 ref_clock_out[0];
    endproperty
    a_ref_shape: assert property (p_ref_shape) else $error("ref shape");
    property p_ref_pair;
        clock_source_strap && !off_reg && !$past(off_reg, 2) |->
            ref_clock_out[1] == ref_clock_out[0];
    endproperty
    a_ref_pair: assert property (p_ref_pair) else $error("ref pair");
    property p_ref_off;
        (off_reg && $past(off_reg, 2)) || !clock_source_strap |-> !ref_clock_out[1];
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref off");
    property p_stat;
        reg_rd && reg_addr == `RSP_REG_STAT |=> reg_rdata[2:0] ==
            {!clock_source_strap, !port4_iface_strap, !port3_iface_strap};
    endproperty
    a_stat: assert property (p_stat) else $error("stat mode");
    property p_unmapped;
        reg_rd && reg_addr != `RSP_REG_CTRL && reg_addr != `RSP_REG_STAT |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_ready_beat;
        sw_rx_ready[0] |=> !sw_rx_ready[0] [*4];
    endproperty
    a_ready_beat: assert property (p_ready_beat) else $error("ready beat");
    property p_dibit_out;
        sw_rx_ready[1] |=> rx_valid_carrier_out[1] == $past(sw_rx_valid[1]) &&
            rx_dibit_out[3:2] == ($past(sw_rx_valid[1]) ? $past(sw_rx_data[9:8]) : 2'h0);
    endproperty
    a_dibit_out: assert property (p_dibit_out) else $error("first dibit");
    property p_idle_zero;
        !rx_valid_carrier_out[0] |-> rx_dibit_out[1:0] == 2'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle dibit");
    property p_hold;
        rx_valid_carrier_out[0] && $changed(rx_dibit_out[1:0]) |=> $stable(rx_dibit_out[1:0]) [*4];
    endproperty
    a_hold: assert property (p_hold) else $error("dibit hold");
endmodule // rsp_port_monitor
bind rsp_port rsp_port_monitor mon (.*);
`default_nettype wire

// ---- test/rsp_mac_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsp_mac_model (
    // Reference clock and reference cycles per dibit.
    input wire logic ref_clk,
    input wire logic [3:0] hold,
    // Toward the port's transmit pins.
    output logic tx_en,
    output logic [1:0] tx_dibit,
    // From the port's receive pins.
    input wire logic rx_valid,
    input wire logic [1:0] rx_dibit
);
    logic [7:0] rx_q[$];
    logic [7:0] sh_reg = 8'h00;
    int k = 0;
    int n = 0;
    // Idle at start.
    initial begin
        tx_en = 1'b0;
        tx_dibit = 2'h0;
    end
    // Sends a frame, low dibit first, each dibit held for hold reference cycles.
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            for (int d = 0; d < 4; d++) begin
                repeat (hold) begin
                    @(posedge ref_clk);
                    tx_en <= 1'b1;
                    tx_dibit <= b[i][2*d +: 2];
                end
            end
        end
        @(posedge ref_clk);
        tx_en <= 1'b0;
        tx_dibit <= ~tx_dibit; // The released line does not keep the last dibit.
    endtask
    // Takes the first sample of each held dibit and packs four into a byte.
    always @(posedge ref_clk) begin
        if (!rx_valid) begin
            k = 0;
            n = 0;
        end else begin
            if (k == 0) begin
                sh_reg = {rx_dibit, sh_reg[7:2]};
                n = n + 1;
            end
            if (k == 0 && n == 4) begin
                rx_q.push_back(sh_reg);
                n = 0;
            end
            k = (k + 1 == hold) ? 0 : k + 1;
        end
    end
endmodule // rsp_mac_model
`default_nettype wire

// ---- test/rsp_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rsp_consts.vh"
module rsp_port_tb;
    localparam int LIM = 4000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic port3_iface_strap = 1'b0;
    logic port4_iface_strap = 1'b0;
    logic clock_source_strap = 1'b1;
    logic link_clk = 1'b0;
    logic sel = 1'b0;
    logic [3:0] hold = 4'h1;
    logic [1:0] sw_tx_ready = 2'h0;
    logic [15:0] sw_rx_data = 16'h0000;
    logic [1:0] sw_rx_valid = 2'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [1:0] ref_clock_out, rx_valid_carrier_out, sw_tx_first, sw_tx_valid, sw_rx_ready;
    wire [1:0] tx_enable_in, m_dibit;
    wire [3:0] rx_dibit_out, tx_dibit_in;
    wire [15:0] sw_tx_data;
    wire [7:0] reg_rdata;
    wire m_en, m_ref;
    int failures = 0;
    int tests_run = 0;
    int h3, h4;
    logic [7:0] q[$];
    // System clock and the external link reference.
    always #2 clk_sys = ~clk_sys;
    always #32 link_clk = ~link_clk;
    // One partner serves the port picked by sel; the other port sees no enable.
    assign tx_enable_in = sel ? {m_en, 1'b0} : {1'b0, m_en};
    assign tx_dibit_in = {m_dibit, m_dibit};
    assign m_ref = clock_source_strap ? ref_clock_out[0] : link_clk;
    rsp_port uut (.clk_sys(clk_sys), .rst(rst), .port3_iface_strap(port3_iface_strap),
        .port4_iface_strap(port4_iface_strap), .clock_source_strap(clock_source_strap),
        .ref_clock_in({link_clk, 1'b0}),
        .ref_clock_out(ref_clock_out), .tx_enable_in(tx_enable_in), .tx_dibit_in(tx_dibit_in),
        .rx_valid_carrier_out(rx_valid_carrier_out), .rx_dibit_out(rx_dibit_out),
        .sw_tx_data(sw_tx_data), .sw_tx_first(sw_tx_first), .sw_tx_valid(sw_tx_valid),
        .sw_tx_ready(sw_tx_ready), .sw_rx_data(sw_rx_data), .sw_rx_valid(sw_rx_valid),
        .sw_rx_ready(sw_rx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Wired as a far MAC; a far PHY uses the same pins, so no mode is set.
    rsp_mac_model m (.ref_clk(m_ref), .hold(hold), .tx_en(m_en), .tx_dibit(m_dibit),
        .rx_valid(rx_valid_carrier_out[sel]), .rx_dibit(rx_dibit_out[2*sel +: 2]));
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= LIM) begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        check("reg_rdata", 16'(reg_rdata), 16'(exp));
        @(posedge clk_sys);
    endtask
    task automatic do_reset(input logic cs, input logic p3);
        rst <= 1'b1;
        clock_source_strap <= cs;
        port3_iface_strap <= p3;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Offers bytes from the switch side, each held until the port takes it.
    task automatic sw_send(input int p, input logic [7:0] b[$]);
        int i;
        foreach (b[j]) begin
            sw_rx_data[8*p +: 8] <= b[j];
            sw_rx_valid[p] <= 1'b1;
            for (i = 0; i < LIM; i++) begin
                @(negedge clk_sys);
                if (sw_rx_ready[p] === 1'b1)
                    break;
            end
            tmo(i);
            @(posedge clk_sys);
        end
        sw_rx_valid[p] <= 1'b0;
    endtask
    // Pops bytes from the port's buffer and compares them.
    task automatic sw_expect(input int p, input logic [7:0] b[$]);
        int i;
        foreach (b[j]) begin
            for (i = 0; i < LIM; i++) begin
                @(negedge clk_sys);
                if (sw_tx_valid[p] === 1'b1)
                    break;
            end
            tmo(i);
            check("sw_tx_data", 16'(sw_tx_data[8*p +: 8]), 16'(b[j]));
            check("sw_tx_first", 16'(sw_tx_first[p]), 16'(j == 0));
            @(posedge clk_sys);
            sw_tx_ready[p] <= 1'b1;
            @(posedge clk_sys);
            sw_tx_ready[p] <= 1'b0;
        end
    endtask
    // Runs traffic both ways at once on port p.
    task automatic xfer(input int p, input logic [7:0] a[$], input logic [7:0] b[$]);
        int i;
        m.rx_q.delete();
        fork
            m.send(a);
            sw_expect(p, a);
            sw_send(p, b);
        join
        for (i = 0; i < LIM && m.rx_q.size() < b.size(); i++)
            @(negedge clk_sys);
        tmo(i);
        foreach (b[j])
            check("link_rx", 16'(m.rx_q[j]), 16'(b[j]));
        @(posedge clk_sys);
    endtask
    // Watchdog, so a stalled reference clock still reaches the verdict.
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        print_verdict();
    end
    // Main sequence.
    initial begin
        do_reset(1'b1, 1'b0);
        rd(`RSP_REG_CTRL, `RSP_CTRL_RESET);
        rd(`RSP_REG_STAT, 8'h03);
        wr(8'h99, 8'hff);
        rd(8'h99, 8'h00);
        rd(`RSP_REG_CTRL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(`RSP_REG_CTRL, k ? 8'h08 : 8'h00);
            h3 = 0;
            h4 = 0;
            repeat (50) begin
                @(negedge clk_sys);
                h3 += (ref_clock_out[0] === 1'b1);
                h4 += (ref_clock_out[1] === 1'b1);
            end
            check("ref3_high", 16'(h3), 16'd20);
            check("ref4_high", 16'(h4), k ? 16'd0 : 16'd20);
            @(posedge clk_sys);
        end
        for (int s = 0; s < 2; s++) begin
            hold <= s ? 4'ha : 4'h1;
            wr(`RSP_REG_CTRL, s ? 8'h03 : 8'h00);
            for (int p = 0; p < 2; p++) begin
                sel <= p[0];
                xfer(p, '{8'h3c, 8'hff}, '{8'h00, 8'hc3});
            end
        end
        hold <= 4'h1;
        sel <= 1'b0;
        wr(`RSP_REG_CTRL, 8'h00);
        for (int i = 0; i < 17; i++)
            q.push_back(8'(8'h11 * i));
        m.send(q);
        repeat (2) @(posedge m_ref);
        @(posedge clk_sys);
        rd(`RSP_REG_STAT, 8'h13);
        void'(q.pop_back());
        sw_expect(0, q);
        @(negedge clk_sys);
        check("sw_tx_valid", 16'(sw_tx_valid), 16'h0000);
        @(posedge clk_sys);
        wr(`RSP_REG_STAT, 8'h10);
        rd(`RSP_REG_STAT, 8'h03);
        do_reset(1'b0, 1'b1);
        rd(`RSP_REG_STAT, 8'h06);
        sel <= 1'b1;
        xfer(1, '{8'h96}, '{8'h69});
        @(negedge clk_sys);
        check("ref4_out", 16'(ref_clock_out[1]), 16'h0000);
        print_verdict();
    end
endmodule // rsp_port_tb
`default_nettype wire
